// ==== core/plocfg_top.sv ====
// Summary of operation
// - After PLL write or sleep re-enable, wait lock count slow cycles (one when the count is zero), then lock.
// - VCO ratio is (mul+1)/div, or 2*(mul+1) when div is zero.
// - PLL input is source when div zero, else source over twice div.
// - Option bit 1 set halves the PLL output; clear passes VCO frequency.
// - Option bit 0 picks VCO range: 0 high range, 1 low range.
// - Option bit 2 clear keeps wide bandwidth on; set turns it off.
// - Source bit picks oscillator 0 or 1; enable bit switches PLL.
// - Main oscillator start-up codes 0-6 give 0 to 16384 RC cycles.
// - Main mode 0 takes external clock, output pin free; 1-3 reserved.
// - Main modes 4-7 drive a crystal with four rising gain steps.
// - Slow oscillator start-up codes give 0 to 524288 RC cycles.
// - Slow mode 0 takes external clock, 1 drives crystal, rest reserved.
// - Slow oscillator control register resets only on power-on reset.
// - Slow oscillator enable bit stops or runs that oscillator.
// - Rising edge of live lock sets the sticky lock interrupt flag.
`timescale 1ns/10ps
`default_nettype none

module plocfg_top
	import plocfg_pkg::*;
#(
	parameter int STARTUP_SHIFT = 0
) (
	// Clock and resets
	input  wire logic          clock,
	input  wire logic          resetn,
	input  wire logic          por_resetn,
	// Register port
	input  wire logic [7:0]    addr,
	input  wire logic [31:0]   wdata,
	input  wire logic          write,
	input  wire logic          read,
	output logic [31:0]        rdata,
	// Slow clock, RC clock and power events
	input  wire logic          slow_clock_pin,
	input  wire logic          rc_clock_pin,
	input  wire logic          sleep_exit,
	input  wire logic [1:0]    main_osc_enable,
	// Analog controls
	output plocfg_pll_t [1:0]  pll_cfg,
	output plocfg_osc_t [1:0]  main_osc_cfg,
	output plocfg_osc_t        slow_osc_cfg,
	// Status
	output logic [1:0]         loop_locked_flag,
	output logic [2:0]         osc_ready,
	output logic               irq
);

	// ==================================================================
	// Helpers
	function automatic logic [19:0] main_startup(input logic [2:0] code);
		unique case (code)
			3'h0: main_startup = 20'h00000;
			3'h1: main_startup = 20'h00040;
			3'h2: main_startup = 20'h00080;
			3'h3: main_startup = 20'h00800;
			3'h4: main_startup = 20'h01000;
			3'h5: main_startup = 20'h02000;
			3'h6: main_startup = 20'h04000;
			// Reserved code 7 falls back to the longest wait, the safe side
			default: main_startup = 20'h04000;
		endcase
	endfunction

	function automatic logic [19:0] slow_startup(input logic [2:0] code);
		unique case (code)
			3'h0: slow_startup = 20'h00000;
			3'h1: slow_startup = 20'h00080;
			3'h2: slow_startup = 20'h02000;
			3'h3: slow_startup = 20'h04000;
			3'h4: slow_startup = 20'h10000;
			3'h5: slow_startup = 20'h20000;
			3'h6: slow_startup = 20'h40000;
			3'h7: slow_startup = 20'h80000;
		endcase
	endfunction

	function automatic plocfg_osc_t main_decode(input logic en, input logic [2:0] mode);
		plocfg_osc_t o;
		o = '0;
		o.enable        = en;
		o.crystal_drive = en && (mode >= MODE_FIRST_XTAL);
		o.gain_step     = mode[1:0];
		// Reserved modes keep the crystal amplifier off
		o.out_pin_free  = (mode < MODE_FIRST_XTAL);
		return o;
	endfunction

	// Ratio and divider fields handed to the analog loop
	function automatic plocfg_pll_t pll_decode(input logic [31:0] r);
		plocfg_pll_t p;
		logic [3:0]  div_code;
		logic [4:0]  mul_plus;
		p        = '0;
		div_code = r[PLL_DIV_LSB +: 4];
		mul_plus = {1'b0, r[PLL_MUL_LSB +: 4]} + 5'h01;
		p.enable        = r[PLL_EN_BIT];
		p.source_osc1   = r[PLL_SRC_BIT];
		p.low_vco_range = r[PLL_OPT_LSB + OPT_RANGE_BIT];
		p.out_half      = r[PLL_OPT_LSB + OPT_HALF_BIT];
		p.wide_band     = !r[PLL_OPT_LSB + OPT_NOWIDE_BIT];
		if (div_code == 4'h0) begin
			// Zero divide doubles the ratio and bypasses the input divider
			p.ratio_num = {mul_plus, 1'b0};
			p.ratio_den = 4'h1;
			p.in_div    = 5'h01;
		end else begin
			p.ratio_num = {1'b0, mul_plus};
			p.ratio_den = div_code;
			p.in_div    = {div_code, 1'b0};
		end
		// Multiply factor 0 or 1 is passed through; software avoids it
		return p;
	endfunction

	// ==================================================================
	// Registers
	logic [31:0] pll_reg [2];
	logic [31:0] osc_reg [2];
	logic [31:0] osc32_reg;
	logic [31:0] irq_stat;
	logic [31:0] irq_mask;
	logic [31:0] live;
	logic [31:0] next_rdata;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pll_reg[0] <= RST_PLL;
			pll_reg[1] <= RST_PLL;
			osc_reg[0] <= RST_OSC;
			osc_reg[1] <= RST_OSC;
			irq_mask   <= '0;
		end else if (write) begin
			unique case (addr)
				ADDR_PLL_ZERO_CONTROL:     pll_reg[0] <= wdata;
				ADDR_PLL_ONE_CONTROL:     pll_reg[1] <= wdata;
				ADDR_OSC0:     osc_reg[0] <= wdata;
				ADDR_OSC1:     osc_reg[1] <= wdata;
				ADDR_IRQ_MASK: irq_mask   <= wdata & IRQ_IMPL;
				default: ;
			endcase
		end
	end

	// Survives every reset but power-on
	always_ff @(posedge clock or negedge por_resetn) begin
		if (!por_resetn) begin
			osc32_reg <= RST_OSC32;
		end else if (write && addr == ADDR_OSC32) begin
			osc32_reg <= wdata;
		end
	end

	always_comb begin
		unique case (addr)
			ADDR_PLL_ZERO_CONTROL:     next_rdata = pll_reg[0];
			ADDR_PLL_ONE_CONTROL:     next_rdata = pll_reg[1];
			ADDR_OSC0:     next_rdata = osc_reg[0];
			ADDR_OSC1:     next_rdata = osc_reg[1];
			ADDR_OSC32:    next_rdata = osc32_reg;
			ADDR_LIVE:     next_rdata = live;
			ADDR_IRQ_STAT: next_rdata = irq_stat;
			ADDR_IRQ_MASK: next_rdata = irq_mask;
			default:       next_rdata = '0;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= '0;
		end else begin
			rdata <= read ? next_rdata : '0;
		end
	end

	// ==================================================================
	// Pin synchronisers and tick detection
	logic [2:0] slow_sync;
	logic [2:0] rc_sync;
	logic       slow_tick;
	logic       rc_tick;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			slow_sync <= '0;
			rc_sync   <= '0;
		end else begin
			slow_sync <= {slow_sync[1:0], slow_clock_pin};
			rc_sync   <= {rc_sync[1:0], rc_clock_pin};
		end
	end

	assign slow_tick = slow_sync[1] && !slow_sync[2];
	assign rc_tick   = rc_sync[1] && !rc_sync[2];

	// ==================================================================
	// PLL lock timing
	logic [5:0] lock_cnt [2];
	logic [1:0] lock_wait;
	logic [1:0] pll_hit;

	assign pll_hit = {write && addr == ADDR_PLL_ONE_CONTROL, write && addr == ADDR_PLL_ZERO_CONTROL};

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lock_cnt[0]      <= '0;
			lock_cnt[1]      <= '0;
			lock_wait        <= '0;
			loop_locked_flag <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (pll_hit[i]) begin
					// Enable taken from the incoming word, so the enabling write arms
					lock_cnt[i]         <= wdata[PLL_CNT_LSB +: 6];
					lock_wait[i]        <= wdata[PLL_EN_BIT];
					loop_locked_flag[i] <= 1'b0;
				end else if (!pll_reg[i][PLL_EN_BIT]) begin
					lock_wait[i]        <= 1'b0;
					loop_locked_flag[i] <= 1'b0;
				end else if (sleep_exit) begin
					lock_cnt[i]         <= pll_reg[i][PLL_CNT_LSB +: 6];
					lock_wait[i]        <= 1'b1;
					loop_locked_flag[i] <= 1'b0;
				end else if (lock_wait[i] && slow_tick) begin
					lock_cnt[i] <= lock_cnt[i] - 6'h01;
					if (lock_cnt[i] <= 6'h01) begin
						lock_wait[i]        <= 1'b0;
						loop_locked_flag[i] <= 1'b1;
					end
				end
			end
		end
	end

	// ==================================================================
	// Oscillator start-up timing
	logic [19:0] start_cnt [3];
	logic [2:0]  start_armed;
	logic [2:0]  osc_on;
	logic [19:0] start_len [3];

	always_comb begin
		osc_on       = {osc32_reg[O32_EN_BIT], main_osc_enable};
		start_len[0] = main_startup(osc_reg[0][OSC_START_LSB +: 3]) >> STARTUP_SHIFT;
		start_len[1] = main_startup(osc_reg[1][OSC_START_LSB +: 3]) >> STARTUP_SHIFT;
		start_len[2] = slow_startup(osc32_reg[O32_START_LSB +: 3]) >> STARTUP_SHIFT;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 3; i++)
				start_cnt[i] <= '0;
			start_armed <= '0;
			osc_ready   <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!osc_on[i]) begin
					start_armed[i] <= 1'b0;
					osc_ready[i]   <= 1'b0;
				end else if (!start_armed[i]) begin
					start_cnt[i]   <= start_len[i];
					start_armed[i] <= 1'b1;
				end else if (start_cnt[i] == '0) begin
					osc_ready[i] <= 1'b1;
				end else if (rc_tick) begin
					start_cnt[i] <= start_cnt[i] - 20'h00001;
				end
			end
		end
	end

	// ==================================================================
	// Live status and sticky interrupt flags
	logic [31:0] live_q;
	logic [31:0] rise;

	always_comb begin
		live            = '0;
		live[ST_LOCK0]  = loop_locked_flag[0];
		live[ST_LOCK1]  = loop_locked_flag[1];
		live[ST_OSC0]   = osc_ready[0];
		live[ST_OSC1]   = osc_ready[1];
		live[ST_OSC32]  = osc_ready[2];
		rise            = live & ~live_q;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			live_q   <= '0;
			irq_stat <= '0;
		end else begin
			live_q <= live;
			// A set in the clearing cycle wins
			if (write && addr == ADDR_IRQ_STAT)
				irq_stat <= (irq_stat & ~wdata) | rise;
			else
				irq_stat <= irq_stat | rise;
		end
	end

	// Registered so the pin never glitches while status bits settle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ==================================================================
	// Analog control outputs
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pll_cfg <= '0;
		end else begin
			for (int i = 0; i < 2; i++)
				pll_cfg[i] <= pll_decode(pll_reg[i]);
		end
	end

	// Crystal drive follows the live enable, not only the register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			main_osc_cfg <= '0;
		end else begin
			for (int i = 0; i < 2; i++)
				main_osc_cfg[i] <= main_decode(main_osc_enable[i],
					osc_reg[i][OSC_MODE_LSB +: 3]);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			slow_osc_cfg <= '0;
		end else begin
			slow_osc_cfg.enable        <= osc32_reg[O32_EN_BIT];
			slow_osc_cfg.crystal_drive <= osc32_reg[O32_EN_BIT]
				&& (osc32_reg[O32_MODE_LSB +: 3] == MODE32_CRYSTAL);
			slow_osc_cfg.gain_step     <= 2'h0;
			slow_osc_cfg.out_pin_free  <= (osc32_reg[O32_MODE_LSB +: 3] != MODE32_CRYSTAL);
		end
	end

endmodule // plocfg_top

`default_nettype wire

// ==== pkg/plocfg_pkg.sv ====
package plocfg_pkg;

	// ==================================================================
	// Register map
	localparam logic [7:0] ADDR_PLL_ZERO_CONTROL      = 8'h20;
	localparam logic [7:0] ADDR_PLL_ONE_CONTROL      = 8'h24;
	localparam logic [7:0] ADDR_OSC0      = 8'h28;
	localparam logic [7:0] ADDR_OSC1      = 8'h2c;
	localparam logic [7:0] ADDR_OSC32     = 8'h30;
	localparam logic [7:0] ADDR_LIVE      = 8'h40;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h44;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h48;

	localparam logic [31:0] RST_PLL   = 32'h0000_0000;
	localparam logic [31:0] RST_OSC   = 32'h0000_0000;
	localparam logic [31:0] RST_OSC32 = 32'h0001_0000;

	// ==================================================================
	// Control fields
	localparam int PLL_EN_BIT    = 0;
	localparam int PLL_SRC_BIT   = 1;
	localparam int PLL_OPT_LSB   = 2;
	localparam int PLL_DIV_LSB   = 8;
	localparam int PLL_MUL_LSB   = 16;
	localparam int PLL_CNT_LSB   = 24;
	localparam int OPT_RANGE_BIT = 0;
	localparam int OPT_HALF_BIT  = 1;
	localparam int OPT_NOWIDE_BIT = 2;
	localparam int OSC_MODE_LSB  = 0;
	localparam int OSC_START_LSB = 8;
	localparam int O32_EN_BIT    = 0;
	localparam int O32_MODE_LSB  = 8;
	localparam int O32_START_LSB = 16;

	// Live status and interrupt bit positions
	localparam int ST_LOCK0  = 0;
	localparam int ST_LOCK1  = 1;
	localparam int ST_OSC0   = 7;
	localparam int ST_OSC1   = 8;
	localparam int ST_OSC32  = 9;
	localparam logic [31:0] IRQ_IMPL = 32'h0000_0383;

	// ==================================================================
	// Oscillator modes
	localparam logic [2:0] MODE_EXT_CLOCK  = 3'h0;
	localparam logic [2:0] MODE_FIRST_XTAL = 3'h4;
	localparam logic [2:0] MODE32_CRYSTAL  = 3'h1;

	// ==================================================================
	// Carriers
	typedef struct packed {
		logic       enable;
		logic       source_osc1;
		logic       low_vco_range;
		logic       out_half;
		logic       wide_band;
		logic [5:0] ratio_num;
		logic [3:0] ratio_den;
		logic [4:0] in_div;
	} plocfg_pll_t;

	typedef struct packed {
		logic       enable;
		logic       crystal_drive;
		logic [1:0] gain_step;
		logic       out_pin_free;
	} plocfg_osc_t;

endpackage

// ==== bench/plocfg_top_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module plocfg_top_monitor
	import plocfg_pkg::*;
(
	// Clock and bus
	input wire logic              clock,
	input wire logic              resetn,
	input wire logic [7:0]        addr,
	input wire logic [31:0]       wdata,
	input wire logic              write,
	input wire logic              read,
	input wire logic [31:0]       rdata,
	// Events and status
	input wire logic              slow_clock_pin,
	input wire logic [1:0]        main_osc_enable,
	input wire plocfg_pll_t [1:0] pll_cfg,
	input wire plocfg_osc_t [1:0] main_osc_cfg,
	input wire plocfg_osc_t       slow_osc_cfg,
	input wire logic [1:0]        loop_locked_flag,
	input wire logic [2:0]        osc_ready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// ==========
	// Cycles since the last slow pin rise, saturating
	logic [3:0]  since_rise;
	logic        slow_d;
	logic [31:0] wd_1;
	logic [31:0] wd_2;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			since_rise <= 4'hf;
			slow_d     <= 1'b0;
			wd_1       <= '0;
			wd_2       <= '0;
		end else begin
			slow_d <= slow_clock_pin;
			// Write data two cycles back, for the decode checks
			wd_1   <= wdata;
			wd_2   <= wd_1;
			if (slow_clock_pin && !slow_d)
				since_rise <= 4'h0;
			else if (since_rise != 4'hf)
				since_rise <= since_rise + 4'h1;
		end
	end
	sequence s_osc0_on;
		!main_osc_enable[0] ##1 main_osc_enable[0];
	endsequence
	property p_pll_one_control;
		write && addr == ADDR_PLL_ONE_CONTROL |-> ##2 pll_cfg[1].wide_band == !wd_2[4]
			&& pll_cfg[1].out_half == wd_2[3] && pll_cfg[1].low_vco_range == wd_2[2]
			&& pll_cfg[1].source_osc1 == wd_2[1] && pll_cfg[1].enable == wd_2[0];
	endproperty
	property p_osc1;
		write && addr == ADDR_OSC1 |-> ##2
			main_osc_cfg[1].gain_step == wd_2[1:0] && main_osc_cfg[1].out_pin_free == !wd_2[2]
			&& main_osc_cfg[1].crystal_drive == ($past(main_osc_enable[1]) && wd_2[2]);
	endproperty
	property p_slow;
		write && addr == ADDR_OSC32 |-> ##2 slow_osc_cfg.enable == wd_2[0]
			&& slow_osc_cfg.crystal_drive == (wd_2[0] && wd_2[10:8] == 3'h1);
	endproperty
	a_rdata_idle: assert property (!$past(read) |-> rdata == 32'h0)
		else $error("rdata not zero outside read answer");
	a_pll_fields: assert property (p_pll_one_control)
		else $error("pll option decode wrong");
	a_osc_mode: assert property (p_osc1)
		else $error("main osc mode decode wrong");
	a_slow_cfg: assert property (p_slow)
		else $error("slow osc decode wrong");
	a_lock_tick: assert property ($rose(loop_locked_flag[0]) |-> since_rise inside {[2:7]}
		&& pll_cfg[0].enable)
		else $error("lock rose away from slow tick");
	a_lock_off: assert property (write && addr == ADDR_PLL_ZERO_CONTROL && !wdata[0]
		|-> ##2 !loop_locked_flag[0] [*4])
		else $error("lock stays with pll off");
	a_ready_gap: assert property (s_osc0_on |-> !osc_ready[0] [*2])
		else $error("ready too soon after enable");
	a_ready_drop: assert property (!main_osc_enable[0] |=> !osc_ready[0])
		else $error("ready kept after disable");
endmodule // plocfg_top_monitor
bind plocfg_top plocfg_top_monitor u_mon (.clock(clock), .resetn(resetn), .addr(addr),
	.wdata(wdata), .write(write), .read(read), .rdata(rdata),
	.slow_clock_pin(slow_clock_pin), .main_osc_enable(main_osc_enable),
	.pll_cfg(pll_cfg), .main_osc_cfg(main_osc_cfg), .slow_osc_cfg(slow_osc_cfg),
	.loop_locked_flag(loop_locked_flag), .osc_ready(osc_ready));
`default_nettype wire

// ==== bench/plocfg_top_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module plocfg_top_bench
	import plocfg_pkg::*;
;
	logic              clock = 1'b0;
	logic              resetn = 1'b0;
	logic              por_resetn = 1'b0;
	logic [7:0]        addr = 8'h0;
	logic [31:0]       wdata = 32'h0;
	logic              write = 1'b0;
	logic              read = 1'b0;
	logic              slow_clock_pin = 1'b0;
	logic              sleep_exit = 1'b0;
	logic [1:0]        main_osc_enable = 2'h0;
	logic [1:0]        rc_div = 2'h0;
	logic              rd_d = 1'b0;
	wire logic         rc_clock_pin;
	logic [31:0]       rdata;
	plocfg_pll_t [1:0] pll_cfg;
	plocfg_osc_t [1:0] main_osc_cfg;
	plocfg_osc_t       slow_osc_cfg;
	logic [1:0]        loop_locked_flag;
	logic [2:0]        osc_ready;
	logic              irq;
	logic [31:0]       seed = 32'h7e33728c;
	logic [31:0]       w;
	logic [31:0]       exp_q[$];
	int                bad_count = 0;
	int                n_checks = 0;
	always #5 clock = ~clock;
	// RC clock at a quarter of the bus clock
	always @(posedge clock) rc_div <= rc_div + 2'h1;
	assign rc_clock_pin = rc_div[1];
	plocfg_top #(.STARTUP_SHIFT(8)) DUT (.clock(clock), .resetn(resetn),
		.por_resetn(por_resetn), .addr(addr), .wdata(wdata), .write(write), .read(read),
		.rdata(rdata), .slow_clock_pin(slow_clock_pin), .rc_clock_pin(rc_clock_pin),
		.sleep_exit(sleep_exit), .main_osc_enable(main_osc_enable), .pll_cfg(pll_cfg),
		.main_osc_cfg(main_osc_cfg), .slow_osc_cfg(slow_osc_cfg),
		.loop_locked_flag(loop_locked_flag), .osc_ready(osc_ready), .irq(irq));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		write <= 1'b1;
		@(posedge clock);
		write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		exp_q.push_back(e);
		addr <= a;
		read <= 1'b1;
		@(posedge clock);
		read <= 1'b0;
	endtask
	// Read answers stand one cycle only
	always @(posedge clock) begin
		if (rd_d)
			chk("rdata", exp_q.pop_front(), rdata);
		rd_d <= read;
	end
	task automatic tick();
		@(posedge clock);
		slow_clock_pin <= 1'b1;
		repeat (4) @(posedge clock);
		slow_clock_pin <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	// Margins of three RC ticks absorb synchroniser and phase
	task automatic ready_case(input logic [7:0] a, input logic [31:0] v, input int b,
		input int t);
		wr(a, v);
		main_osc_enable <= 2'h3;
		repeat (t * 4 - 12) @(posedge clock);
		chk("ready low", 32'h0, 32'(osc_ready[b]));
		repeat (24) @(posedge clock);
		chk("ready high", 32'h1, 32'(osc_ready[b]));
		wr(a, 32'h0);
		main_osc_enable <= 2'h0;
		repeat (4) @(posedge clock);
	endtask
	function automatic plocfg_pll_t exp_pll(input logic [31:0] v);
		logic [3:0] dv;
		logic [4:0] m1;
		dv = v[11:8];
		m1 = {1'b0, v[19:16]} + 5'h1;
		exp_pll.enable = v[0];
		exp_pll.source_osc1 = v[1];
		exp_pll.low_vco_range = v[2];
		exp_pll.out_half = v[3];
		exp_pll.wide_band = !v[4];
		exp_pll.ratio_num = (dv == 4'h0) ? {m1, 1'b0} : {1'b0, m1};
		exp_pll.ratio_den = (dv == 4'h0) ? 4'h1 : dv;
		exp_pll.in_div = (dv == 4'h0) ? 5'h1 : {dv, 1'b0};
	endfunction
	task end_of_test();
		$display("Checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		por_resetn <= 1'b1;
		rd(ADDR_PLL_ZERO_CONTROL, RST_PLL);
		rd(ADDR_OSC1, RST_OSC);
		rd(ADDR_OSC32, RST_OSC32);
		rd(8'h3c, 32'h0);
		// ==========
		for (int i = 0; i < 8; i++) begin
			w = $random(seed) & 32'h3f0f0f1f;
			if (i == 0)
				w[11:8] = 4'h0;
			if (w[19:16] < 4'h2)
				w[17] = 1'b1;
			wr(ADDR_PLL_ONE_CONTROL, w);
			repeat (2) @(posedge clock);
			chk("pll_cfg", 32'(exp_pll(w)), 32'(pll_cfg[1]));
			rd(ADDR_PLL_ONE_CONTROL, w);
		end
		wr(ADDR_PLL_ONE_CONTROL, 32'h0);
		main_osc_enable <= 2'h2;
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_OSC1, m);
			repeat (2) @(posedge clock);
			chk("osc_cfg", {27'h0, 1'b1, m > 3, 2'(m), m < 4}, 32'(main_osc_cfg[1]));
		end
		main_osc_enable <= 2'h0;
		wr(ADDR_IRQ_STAT, 32'hffffffff);
		// ==========
		wr(ADDR_IRQ_MASK, 32'hffffffff);
		rd(ADDR_IRQ_MASK, IRQ_IMPL);
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_PLL_ZERO_CONTROL, 32'h03020001);
		for (int k = 0; k < 2; k++) begin
			repeat (2) tick();
			chk("lock early", 32'h0, 32'(loop_locked_flag[0]));
			tick();
			chk("lock", 32'h1, 32'(loop_locked_flag[0]));
			chk("irq set", 32'h1, 32'(irq));
			rd(ADDR_IRQ_STAT, 32'h1);
			wr(ADDR_IRQ_STAT, 32'h1);
			repeat (3) @(posedge clock);
			chk("irq clear", 32'h0, 32'(irq));
			sleep_exit <= 1'b1;
			@(posedge clock);
			sleep_exit <= 1'b0;
			repeat (3) @(posedge clock);
		end
		wr(ADDR_PLL_ZERO_CONTROL, 32'h03020000);
		repeat (6) @(posedge clock);
		// ==========
		ready_case(ADDR_OSC0, 32'h00000300, 0, 8);
		ready_case(ADDR_OSC1, 32'h00000407, 1, 16);
		ready_case(ADDR_OSC0, 32'h00000604, 0, 64);
		ready_case(ADDR_OSC1, 32'h00000700, 1, 64);
		ready_case(ADDR_OSC32, 32'h00020101, 2, 32);
		// ==========
		wr(ADDR_PLL_ZERO_CONTROL, 32'h03020001);
		wr(ADDR_OSC32, 32'h00050300);
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		rd(ADDR_PLL_ZERO_CONTROL, RST_PLL);
		rd(ADDR_OSC32, 32'h00050300);
		repeat (3) @(posedge clock);
		end_of_test();
	end
endmodule // plocfg_top_bench
`default_nettype wire
